// ===== hw/sync_clock_rx.sv
// Simple sync interrupt gating and clock sync receive handling
`timescale 1ns/1ps
`include "sync_clock_map.svh"
module sync_clock_rx
  import sync_clock_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Mode and interrupt controls
  input wire logic exchangeInterruptPortEnable,
  input wire logic syncOutputEnable,
  input wire logic syncPolarity,
  input wire logic outputDataIntMask,
  input wire logic [7:0] controlCommandReg,
  input wire logic [7:0] groupSelectReg,
  // Received telegram events
  input wire logic dataExchangeRcvd,
  input wire logic gcRcvd,
  input wire gc_req_t gcReq,
  input wire logic timeEventRcvd,
  input wire byte_strm_t clkValStrm,
  input wire byte_strm_t prmStrm,
  // Host acknowledges
  input wire logic outputDataAck,
  input wire logic gcAck,
  input wire logic clockSyncAck,
  // Host buffer read
  input wire logic bufRead,
  input wire logic [4:0] bufAddr,
  output logic [7:0] bufData_q,
  // Interrupts and sync
  output logic output_data_interrupt_q,
  output logic global_control_interrupt_q,
  output logic syncOut_q,
  output logic clockSyncInterrupt_q,
  // Clock sync status
  output logic [31:0] rxDelayTimer_q,
  output logic timerRunning_q,
  output logic setTime_q,
  output logic clockSyncViolation_q,
  output clk_val_status_t clkValStatus_q,
  output logic [15:0] syncInterval_q,
  output logic [63:0] csDelayTime_q,
  output logic prmAccepted_q
);

  function automatic logic [4:0] satInc(input logic [4:0] v);
    satInc = (v == `CNT_SAT) ? v : v + 5'h01;
  endfunction

  // Simple sync path
  logic dxPending_q, dxPending_d;
  logic dxReq_q, dxReq_d;
  logic gcInt_d;
  wire simpleMode = exchangeInterruptPortEnable & ~syncOutputEnable;
  wire synchHit = gcRcvd && gcReq.command == controlCommandReg
                  && gcReq.group == groupSelectReg;
  wire dxRaise = simpleMode ? (synchHit & dxPending_q) : dataExchangeRcvd;
  wire dxVisible = dxReq_d & ~outputDataIntMask;

  // A data exchange in the SYNCH cycle stays pending for the next SYNCH
  assign dxPending_d = (simpleMode & dataExchangeRcvd) | (dxPending_q & ~synchHit);
  assign dxReq_d = dxRaise | (dxReq_q & ~outputDataAck);
  assign gcInt_d = gcRcvd | (global_control_interrupt_q & ~gcAck);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dxPending_q <= 1'b0;
      dxReq_q <= 1'b0;
      output_data_interrupt_q <= 1'b0;
      global_control_interrupt_q <= 1'b0;
      syncOut_q <= 1'b0;
    end else begin
      dxPending_q <= dxPending_d;
      dxReq_q <= dxReq_d;
      output_data_interrupt_q <= dxVisible;
      global_control_interrupt_q <= gcInt_d;
      syncOut_q <= syncPolarity ^ (simpleMode & dxVisible);
    end
  end

  // Receive delay timer
  timer_state_t timerState_q, timerState_d;
  logic [31:0] timer_d;

  always_comb begin
    timerState_d = timerState_q;
    case (timerState_q)
      TIMER_STOPPED: if (timeEventRcvd) timerState_d = TIMER_RUNNING;
      TIMER_RUNNING: if (bufRead && !timeEventRcvd) timerState_d = TIMER_STOPPED;
      default: timerState_d = TIMER_STOPPED;
    endcase
  end

  assign timer_d = timeEventRcvd ? 32'h0000_0000 :
                   (timerState_q == TIMER_RUNNING) ? rxDelayTimer_q + 32'h0000_0001 :
                   rxDelayTimer_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timerState_q <= TIMER_STOPPED;
      rxDelayTimer_q <= 32'h0000_0000;
      timerRunning_q <= 1'b0;
    end else begin
      timerState_q <= timerState_d;
      rxDelayTimer_q <= timer_d;
      timerRunning_q <= timerState_d == TIMER_RUNNING;
    end
  end

  // Clock value telegram
  logic [4:0] clkValCnt_q;
  mem_wr_t clkValWr;
  wire clkValLocked = clockSyncInterrupt_q;
  wire clkValGood = clkValStrm.valid && clkValStrm.last && clkValCnt_q == `CLKVAL_LAST;
  wire clkValBad = clkValStrm.valid && clkValStrm.last && clkValCnt_q != `CLKVAL_LAST;
  wire clkValAccept = clkValGood & ~clkValLocked;
  // A frame refused while locked must not re-arm the interrupt over old status
  wire clkValNew = clkValAccept | (clkValBad & ~clkValLocked);

  assign clkValWr.en = clkValStrm.valid && !clkValLocked && clkValCnt_q <= `CLKVAL_LAST;
  assign clkValWr.addr = clkValCnt_q;
  assign clkValWr.data = clkValStrm.data;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clkValCnt_q <= 5'h00;
      clockSyncInterrupt_q <= 1'b0;
      setTime_q <= 1'b0;
      clockSyncViolation_q <= 1'b0;
      clkValStatus_q <= '0;
    end else begin
      if (clkValStrm.valid) begin
        clkValCnt_q <= clkValStrm.last ? 5'h00 : satInc(clkValCnt_q);
      end
      // A frame ending in the acknowledge cycle is refused as locked, so the acknowledge wins
      clockSyncInterrupt_q <= clkValNew | (clockSyncInterrupt_q & ~clockSyncAck);
      if (clkValNew) begin
        setTime_q <= clkValAccept;
        clockSyncViolation_q <= clkValBad;
      end
      if (clkValWr.en && clkValCnt_q == `CLKVAL_STATUS1) begin
        clkValStatus_q.corrSign <= clkValStrm.data[7];
        clkValStatus_q.correctionValue <= clkValStrm.data[6:2];
      end
      if (clkValWr.en && clkValCnt_q == `CLKVAL_STATUS2) begin
        clkValStatus_q.announceHourFlag <= clkValStrm.data[7];
        clkValStatus_q.summerTimeFlag <= clkValStrm.data[6];
        clkValStatus_q.syncFailFlag <= clkValStrm.data[0];
      end
    end
  end

  cs_buffer_mem u_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr(clkValWr),
    .rdEn(bufRead),
    .rdAddr(bufAddr),
    .rdData_q(bufData_q)
  );

  // Time parameter block
  logic [4:0] prmCnt_q;
  logic prmOk_q;
  logic [15:0] ivlShadow_q;
  logic [63:0] dlyShadow_q;
  wire prmByteOk =
    (prmCnt_q == `PRM_TYPE_BYTE) ? prmStrm.data == `PRM_TYPE_TIME :
    (prmCnt_q == `PRM_SLOT_BYTE || prmCnt_q == `PRM_RSVD_BYTE) ? prmStrm.data == 8'h00 :
    1'b1;
  wire prmDone = prmStrm.valid && prmStrm.last && prmOk_q && prmByteOk
                 && prmCnt_q >= `PRM_MIN_LAST;
  wire prmDly = prmCnt_q >= `PRM_DLY_FIRST && prmCnt_q <= `PRM_DLY_LAST;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prmCnt_q <= 5'h00;
      prmOk_q <= 1'b1;
      ivlShadow_q <= 16'h0000;
      dlyShadow_q <= 64'h0000_0000_0000_0000;
      syncInterval_q <= 16'h0000;
      csDelayTime_q <= 64'h0000_0000_0000_0000;
      prmAccepted_q <= 1'b0;
    end else if (prmStrm.valid) begin
      prmCnt_q <= prmStrm.last ? 5'h00 : satInc(prmCnt_q);
      prmOk_q <= prmStrm.last | (prmOk_q & prmByteOk);
      if (prmCnt_q == `PRM_IVL_HI) ivlShadow_q[15:8] <= prmStrm.data;
      if (prmCnt_q == `PRM_IVL_LO) ivlShadow_q[7:0] <= prmStrm.data;
      // Cleared per block so an omitted delay never inherits older bytes
      if (prmStrm.last) dlyShadow_q <= 64'h0000_0000_0000_0000;
      else if (prmDly) dlyShadow_q <= {dlyShadow_q[55:0], prmStrm.data};
      if (prmStrm.last) begin
        prmAccepted_q <= prmDone;
        if (prmDone) begin
          syncInterval_q <= (prmCnt_q == `PRM_IVL_LO) ?
                            {ivlShadow_q[15:8], prmStrm.data} : ivlShadow_q;
          csDelayTime_q <= prmDly ? {dlyShadow_q[55:0], prmStrm.data} : dlyShadow_q;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_DX_AFTER_SYNCH: assert property (
    simpleMode && !outputDataIntMask && dxPending_q && synchHit && !outputDataAck
    |=> output_data_interrupt_q)
    else $error("output data interrupt missing after SYNCH");

  AST_NO_SYNC_WITHOUT_DX: assert property (
    simpleMode && !dxReq_q && !dxPending_q && synchHit |=> !output_data_interrupt_q)
    else $error("sync raised without a preceding data exchange");

  AST_MASK_BLOCKS: assert property (
    outputDataIntMask |=> !output_data_interrupt_q && syncOut_q == $past(syncPolarity))
    else $error("sync or interrupt visible while masked");

  AST_HOLD_TILL_ACK: assert property (
    output_data_interrupt_q && !outputDataAck && !outputDataIntMask |=> output_data_interrupt_q)
    else $error("output data interrupt dropped before acknowledge");

  AST_POLARITY: assert property (
    ##1 syncOut_q == ($past(syncPolarity) ^ ($past(simpleMode) && output_data_interrupt_q)))
    else $error("sync output polarity wrong");

  AST_TIMER_START: assert property (
    timeEventRcvd |=> rxDelayTimer_q == 32'h0000_0000 ##1 rxDelayTimer_q == 32'h0000_0001)
    else $error("receive delay timer did not start");

  AST_TIMER_STOP: assert property (
    bufRead && !timeEventRcvd |=> ##1 $stable(rxDelayTimer_q))
    else $error("receive delay timer kept running after read");

  AST_CS_INT: assert property (
    clkValGood && !clockSyncInterrupt_q |=> clockSyncInterrupt_q && setTime_q)
    else $error("clock sync interrupt not raised");

  AST_NO_WRITE_LOCKED: assert property (
    clockSyncInterrupt_q |-> !clkValWr.en)
    else $error("buffer written while interrupt pending");

  AST_SYNCH_MATCH: assert property (
    gcRcvd && gcReq.command != controlCommandReg && simpleMode && dxPending_q |=> dxPending_q)
    else $error("non-matching global control taken as SYNCH");

endmodule

// ===== pkg/sync_clock_map.svh
// Constants for simple sync and clock sync receive handling
`ifndef SYNC_CLOCK_MAP_SVH
`define SYNC_CLOCK_MAP_SVH

// Clock value telegram layout, also the buffer layout
`define CLKVAL_TE_FIRST 5'h00
`define CLKVAL_PREV_FIRST 5'h08
`define CLKVAL_STATUS1 5'h10
`define CLKVAL_STATUS2 5'h11
`define CLKVAL_LAST 5'h11

// Time parameter block layout
`define PRM_TYPE_BYTE 5'h01
`define PRM_SLOT_BYTE 5'h02
`define PRM_RSVD_BYTE 5'h03
`define PRM_IVL_HI 5'h04
`define PRM_IVL_LO 5'h05
`define PRM_DLY_FIRST 5'h06
`define PRM_DLY_LAST 5'h0d
`define PRM_MIN_LAST 5'h05
`define PRM_TYPE_TIME 8'h08
`define PRM_IVL_BASE_MS 10

`define CNT_SAT 5'h1f
`define BUF_WORDS 32

`endif

// ===== pkg/sync_clock_pkg.sv
// Types for simple sync and clock sync receive handling
package sync_clock_pkg;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] group;
  } gc_req_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } byte_strm_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic corrSign;
    logic [4:0] correctionValue;
    logic announceHourFlag;
    logic summerTimeFlag;
    logic syncFailFlag;
  } clk_val_status_t;

  typedef enum logic {
    TIMER_STOPPED,
    TIMER_RUNNING
  } timer_state_t;

endpackage

// ===== hw/cs_buffer_mem.sv
// Clock sync buffer storage with registered read data
`timescale 1ns/1ps
`include "sync_clock_map.svh"
module cs_buffer_mem
  import sync_clock_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Write port
  input wire mem_wr_t wr,
  // Read port
  input wire logic rdEn,
  input wire logic [4:0] rdAddr,
  output logic [7:0] rdData_q
);

  logic [7:0] mem [`BUF_WORDS];

  // No reset on the array; contents are undefined until first written
  always_ff @(posedge clk_sys) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else if (rdEn) begin
      rdData_q <= mem[rdAddr];
    end
  end

endmodule

// ===== test/time_master_model.sv
// Cycle and time master model driving telegram events and byte streams
`timescale 1ns/1ps
module time_master_model
  import sync_clock_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Telegram events
  output logic dataExchangeRcvd,
  output logic gcRcvd,
  output gc_req_t gcReq,
  output logic timeEventRcvd,
  // Byte streams
  output byte_strm_t clkValStrm,
  output byte_strm_t prmStrm
);
  initial begin
    dataExchangeRcvd = 1'b0;
    gcRcvd = 1'b0;
    gcReq = '0;
    timeEventRcvd = 1'b0;
    clkValStrm = '0;
    prmStrm = '0;
  end

  // One telegram event, held for exactly one sampling edge
  task automatic tel(input logic dx, input logic gc, input logic te, input gc_req_t req);
    @(negedge clk_sys);
    dataExchangeRcvd = dx;
    gcRcvd = gc;
    gcReq = req;
    timeEventRcvd = te;
    @(negedge clk_sys);
    dataExchangeRcvd = 1'b0;
    gcRcvd = 1'b0;
    gcReq = ~req;
    timeEventRcvd = 1'b0;
  endtask

  // Broadcast bytes back to back; idle data flips so stale bytes never look valid
  // User data stays out of the structured header bytes
  task automatic send(input bit prm, input logic [7:0] b [32], input int n);
    byte_strm_t s;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      s = '{valid: 1'b1, last: (i == n - 1), data: b[i]};
      if (prm) prmStrm = s;
      else clkValStrm = s;
    end
    @(negedge clk_sys);
    s = '{valid: 1'b0, last: 1'b0, data: ~s.data};
    if (prm) prmStrm = s;
    else clkValStrm = s;
  endtask
endmodule

// ===== test/simple_sync_and_clock_sync_tb_top.sv
// Testbench for simple sync gating and clock sync receive handling
`timescale 1ns/1ps
module simple_sync_and_clock_sync_tb_top
  import sync_clock_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic exchangeInterruptPortEnable, syncOutputEnable, syncPolarity, outputDataIntMask;
  logic [7:0] controlCommandReg, groupSelectReg, bufData_q;
  logic dataExchangeRcvd, gcRcvd, timeEventRcvd, outputDataAck, gcAck, clockSyncAck, bufRead;
  gc_req_t gcReq, synch;
  byte_strm_t clkValStrm, prmStrm;
  logic [4:0] bufAddr;
  logic output_data_interrupt_q, global_control_interrupt_q, syncOut_q, clockSyncInterrupt_q;
  logic [31:0] rxDelayTimer_q;
  logic timerRunning_q, setTime_q, clockSyncViolation_q, prmAccepted_q;
  clk_val_status_t clkValStatus_q;
  logic [15:0] syncInterval_q;
  logic [63:0] csDelayTime_q;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0, tr;
  logic [31:0] seed = 32'h25;
  logic [7:0] frm [32], frm2 [32], p [32], q [32];
  logic [63:0] teRead, teExp, dlyExp, sysSeen;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  time_master_model tm_u (.clk_sys(clk_sys), .dataExchangeRcvd(dataExchangeRcvd),
    .gcRcvd(gcRcvd), .gcReq(gcReq), .timeEventRcvd(timeEventRcvd), .clkValStrm(clkValStrm),
    .prmStrm(prmStrm));

  sync_clock_rx dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .exchangeInterruptPortEnable(exchangeInterruptPortEnable),
    .syncOutputEnable(syncOutputEnable), .syncPolarity(syncPolarity),
    .outputDataIntMask(outputDataIntMask), .controlCommandReg(controlCommandReg),
    .groupSelectReg(groupSelectReg), .dataExchangeRcvd(dataExchangeRcvd), .gcRcvd(gcRcvd),
    .gcReq(gcReq), .timeEventRcvd(timeEventRcvd), .clkValStrm(clkValStrm), .prmStrm(prmStrm),
    .outputDataAck(outputDataAck), .gcAck(gcAck), .clockSyncAck(clockSyncAck),
    .bufRead(bufRead), .bufAddr(bufAddr), .bufData_q(bufData_q),
    .output_data_interrupt_q(output_data_interrupt_q),
    .global_control_interrupt_q(global_control_interrupt_q), .syncOut_q(syncOut_q),
    .clockSyncInterrupt_q(clockSyncInterrupt_q), .rxDelayTimer_q(rxDelayTimer_q),
    .timerRunning_q(timerRunning_q), .setTime_q(setTime_q),
    .clockSyncViolation_q(clockSyncViolation_q), .clkValStatus_q(clkValStatus_q),
    .syncInterval_q(syncInterval_q), .csDelayTime_q(csDelayTime_q),
    .prmAccepted_q(prmAccepted_q));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic clk_val_status_t status_of(input logic [7:0] s1, input logic [7:0] s2);
    return '{s1[7], s1[6:2], s2[7], s2[6], s2[0]};
  endfunction

  // Host system time; the processing delay is a fixed host figure
  function automatic logic [63:0] sys_time(input logic [63:0] te, input logic [63:0] dly,
                                           input logic [63:0] rdDly);
    return te + dly + rdDly + 64'h0000_0000_0000_0003;
  endfunction

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  // Host acknowledges: output data, global control, clock sync
  task automatic ack(input logic [2:0] m);
    @(negedge clk_sys);
    {outputDataAck, gcAck, clockSyncAck} = m;
    @(negedge clk_sys);
    {outputDataAck, gcAck, clockSyncAck} = 3'h0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(negedge clk_sys);
    bufRead = 1'b1;
    bufAddr = a;
    @(negedge clk_sys);
    bufRead = 1'b0;
    bufAddr = ~a;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #25000;
    fail_count++;
    wrap_up();
  end

  initial begin
    {exchangeInterruptPortEnable, syncOutputEnable, syncPolarity, outputDataIntMask} = 4'h8;
    {outputDataAck, gcAck, clockSyncAck, bufRead, bufAddr} = '0;
    {controlCommandReg, groupSelectReg} = 16'(rnd());
    synch = {controlCommandReg, groupSelectReg};
    foreach (frm[i]) begin
      frm[i] = 8'(rnd());
      frm2[i] = 8'(rnd());
      p[i] = 8'(rnd());
    end
    {p[0], p[1], p[2], p[3]} = 32'h0e080000;
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    tm_u.tel(1'b1, 1'b0, 1'b0, '0);
    chk("odiHeld", output_data_interrupt_q, 0);
    tm_u.tel(1'b0, 1'b1, 1'b0, synch);
    chk("odiOnSynch", output_data_interrupt_q, 1);
    chk("gcOnSynch", global_control_interrupt_q, 1);
    repeat (3) @(negedge clk_sys);
    chk("syncHeld", syncOut_q, 1);
    ack(3'h6);
    chk("syncAcked", syncOut_q, 0);
    chk("gcAcked", global_control_interrupt_q, 0);
    tm_u.tel(1'b0, 1'b1, 1'b0, synch);
    chk("noDxSynch", output_data_interrupt_q, 0);
    tm_u.tel(1'b1, 1'b0, 1'b0, '0);
    tm_u.tel(1'b0, 1'b1, 1'b0, synch ^ 16'h0100);
    chk("otherGc", output_data_interrupt_q, 0);
    outputDataIntMask = 1'b1;
    tm_u.tel(1'b0, 1'b1, 1'b0, synch);
    chk("maskedOdi", output_data_interrupt_q, 0);
    chk("maskedSync", syncOut_q, 0);
    outputDataIntMask = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("unmasked", output_data_interrupt_q, 1);
    syncPolarity = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("syncInverted", syncOut_q, 0);
    ack(3'h6);
    chk("syncIdleHigh", syncOut_q, 1);
    syncPolarity = 1'b0;
    syncOutputEnable = 1'b1;
    tm_u.tel(1'b1, 1'b0, 1'b0, '0);
    chk("isoDirect", output_data_interrupt_q, 1);
    chk("isoNoSync", syncOut_q, 0);
    ack(3'h4);
    syncOutputEnable = 1'b0;
    tm_u.tel(1'b0, 1'b0, 1'b1, '0);
    t0 = cyc;
    chk("timerStart", rxDelayTimer_q, 0);
    chk("timerOn", timerRunning_q, 1);
    tm_u.send(1'b0, frm, 18);
    chk("csInt", clockSyncInterrupt_q, 1);
    chk("setTime", setTime_q, 1);
    chk("valStatus", clkValStatus_q, status_of(frm[16], frm[17]));
    chk("timerRuns", rxDelayTimer_q, cyc - t0);
    tm_u.send(1'b0, frm2, 18);
    // First read is sampled two edges on, and the timer counts once more there
    tr = cyc + 2;
    for (int a = 0; a < 18; a++) begin
      rd(5'(a));
      chk("bufByte", bufData_q, frm[a]);
      if (a < 8) begin
        teRead = {teRead[55:0], bufData_q};
        teExp = {teExp[55:0], frm[a]};
      end
    end
    chk("timerStop", rxDelayTimer_q, tr - t0);
    chk("timerOff", timerRunning_q, 0);
    ack(3'h1);
    chk("csAcked", clockSyncInterrupt_q, 0);
    tm_u.send(1'b0, frm2, 10);
    chk("shortFrame", clockSyncViolation_q, 1);
    ack(3'h1);
    tm_u.send(1'b1, p, 14);
    chk("prmOk", prmAccepted_q, 1);
    chk("interval", syncInterval_q, {p[4], p[5]});
    dlyExp = {p[6], p[7], p[8], p[9], p[10], p[11], p[12], p[13]};
    chk("delay", csDelayTime_q, dlyExp);
    sysSeen = sys_time(teRead, csDelayTime_q, rxDelayTimer_q);
    chk("sysTime", sysSeen, sys_time(teExp, dlyExp, tr - t0));
    for (int k = 1; k < 4; k++) begin
      q = p;
      q[k] = q[k] ^ 8'h01;
      q[5] = ~p[5];
      tm_u.send(1'b1, q, 14);
      chk("prmBad", prmAccepted_q, 0);
      chk("intervalKept", syncInterval_q, {p[4], p[5]});
    end
    wrap_up();
  end
endmodule
